/* test/wcs1_bench.sv */
`default_nettype none
module wcs1_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import wcs1_pkg::*;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	wcs1_bus_t bus_req = '0;
	logic energy_efficient_enable = 1'b0;
	logic deep_buffering_suspend = 1'b0;
	logic resume_done = 1'b0;
	wcs1_evt_t evt = '0;
	logic [31:0] rd_data;
	logic remote_wakeup;
	logic frame_store_valid;
	logic frame_store_keep;
	logic irq;
	int num_errors = 0;
	int checks = 0;
	always #50 core_clk = ~core_clk;
	wcs1_top dut
	(
		.core_clk(core_clk), .reset_n(reset_n), .bus_req(bus_req),
		.rd_data(rd_data), .energy_efficient_enable(energy_efficient_enable),
		.deep_buffering_suspend(deep_buffering_suspend),
		.resume_done(resume_done), .evt(evt), .remote_wakeup(remote_wakeup),
		.frame_store_valid(frame_store_valid),
		.frame_store_keep(frame_store_keep), .irq(irq)
	);
	// ----
	// access tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge core_clk);
		bus_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge core_clk);
		bus_req.rd <= 1'b0;
		#1 chk(rd_data, exp);
	endtask
	task automatic fire(input logic [7:0] e, input logic [2:0] exp);
		@(posedge core_clk);
		evt <= e;
		@(posedge core_clk);
		evt <= '0;
		#1 chk({29'h0, remote_wakeup, frame_store_valid, frame_store_keep},
			{29'h0, exp});
	endtask
	task automatic resume(input logic [31:0] ctrl, input logic [31:0] exp);
		wr(12'h148, ctrl);
		@(posedge core_clk);
		resume_done <= 1'b1;
		@(posedge core_clk);
		resume_done <= 1'b0;
		rd(12'h140, exp);
	endtask
	task automatic deep(input logic v);
		@(posedge core_clk);
		deep_buffering_suspend <= v;
		repeat (2) @(posedge core_clk);
	endtask
	task automatic eee(input logic v);
		@(posedge core_clk);
		energy_efficient_enable <= v;
	endtask
	task automatic test_done();
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#1ms;
		num_errors++;
		test_done();
	end
	// ----
	// tests
	// ----
	initial
	begin
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
		// reset values, unmapped place, read back
		rd(12'h140, 32'h0);
		rd(12'h148, 32'h0);
		rd(12'h14C, 32'h0);
		rd(12'h150, 32'h0);
		wr(12'h144, 32'hFFFFFFFF);
		rd(12'h144, 32'h0);
		wr(12'h140, 32'hFFFFFFFF);
		rd(12'h140, 32'h00005500);
		wr(12'h150, 32'h00000004);
		// frames
		fire(8'h14, 3'b010);
		rd(12'h140, 32'h00005500);
		fire(8'h1C, 3'b111);
		chk({31'h0, irq}, 32'h1);
		fire(8'h1B, 3'b010);
		rd(12'h140, 32'h000057C0);
		rd(12'h14C, 32'h0000001C);
		chk({31'h0, irq}, 32'h0);
		fire(8'h1B, 3'b010);
		chk({31'h0, irq}, 32'h0);
		wr(12'h140, 32'h00005500);
		rd(12'h140, 32'h000057C0);
		wr(12'h140, 32'h000057C0);
		rd(12'h140, 32'h00005500);
		// low-power wakes
		fire(8'hC0, 3'b100);
		rd(12'h140, 32'h00005500);
		eee(1'b1);
		fire(8'h80, 3'b100);
		rd(12'h140, 32'h00005500);
		fire(8'hC0, 3'b100);
		fire(8'h20, 3'b100);
		rd(12'h140, 32'h00007D00);
		eee(1'b0);
		rd(12'h140, 32'h00005500);
		eee(1'b1);
		wr(12'h140, 32'h00004100);
		fire(8'hE0, 3'b000);
		rd(12'h140, 32'h00004100);
		// resume
		wr(12'h140, 32'h00005500);
		fire(8'hFF, 3'b111);
		rd(12'h140, 32'h00007FC0);
		resume(32'h0, 32'h00007FC0);
		resume(32'h1, 32'h00002BC0);
		resume(32'h2, 32'h00000100);
		// deep suspend frame storing
		wr(12'h140, 32'h00004100);
		deep(1'b1);
		fire(8'h1C, 3'b111);
		fire(8'h1C, 3'b111);
		deep(1'b0);
		wr(12'h140, 32'h00004000);
		deep(1'b1);
		fire(8'h1C, 3'b110);
		fire(8'h1C, 3'b111);
		deep(1'b0);
		fire(8'h1C, 3'b111);
		wr(12'h140, 32'h00001000);
		deep(1'b1);
		fire(8'h1C, 3'b010);
		fire(8'h80, 3'b100);
		fire(8'h1C, 3'b011);
		deep(1'b0);
		// back to normal operation with every enable clear
		wr(12'h140, 32'h00002AC0);
		rd(12'h140, 32'h00000000);
		chk({31'h0, irq}, 32'h1);
		// reset again in mid-run
		@(posedge core_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		rd(12'h150, 32'h0);
		rd(12'h14C, 32'h0);
		chk({31'h0, irq}, 32'h0);
		test_done();
	end
endmodule // wcs1_bench
`default_nettype wire

/* test/wcs1_checker.sv */
`default_nettype none
module wcs1_checker
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// register port
	input wire wcs1_pkg::wcs1_bus_t bus_req,
	input wire logic [31:0] rd_data,
	// mac state and events
	input wire logic energy_efficient_enable,
	input wire logic deep_buffering_suspend,
	input wire logic resume_done,
	input wire wcs1_pkg::wcs1_evt_t evt,
	// results
	input wire logic remote_wakeup,
	input wire logic frame_store_valid,
	input wire logic frame_store_keep,
	input wire logic irq
);
	import wcs1_pkg::*;
	// ----
	// checks
	// ----
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	a_store_valid:
		assert property (frame_store_valid == $past(evt.frame_done))
		else $error("store valid not after frame end");
	a_rd_idle:
		assert property (!$past(bus_req.rd) |-> rd_data == 32'h0)
		else $error("read data outside read cycle");
	a_unmapped_rd:
		assert property (bus_req.rd && bus_req.addr == 12'h144
			|=> rd_data == 32'h0)
		else $error("unmapped read not zero");
	a_keep_qual:
		assert property (frame_store_keep |-> frame_store_valid
			&& $past(evt.frame_ok && evt.filter_pass))
		else $error("kept frame not qualifying");
	a_normal_keep:
		assert property (!deep_buffering_suspend [*3] ##0 (evt.frame_done
			&& evt.frame_ok && evt.filter_pass) |=> frame_store_keep)
		else $error("good frame dropped outside suspend");
	a_wake_cause:
		assert property (remote_wakeup |-> $past(evt.tx_lpi_exit
			|| evt.rx_lpi_wake || (evt.frame_done && evt.frame_ok
			&& evt.filter_pass)))
		else $error("wakeup without cause");
	a_irq_rise:
		assert property ($rose(irq) |-> $past(evt.tx_lpi_exit
			|| evt.rx_lpi_wake || evt.frame_done || bus_req.wr))
		else $error("interrupt without event");
	a_irq_fall:
		assert property ($fell(irq) |-> $past(bus_req.rd || bus_req.wr
			|| resume_done || !energy_efficient_enable))
		else $error("interrupt dropped without access");
endmodule // wcs1_checker
bind wcs1_top wcs1_checker u_chk
(
	.core_clk(core_clk), .reset_n(reset_n), .bus_req(bus_req),
	.rd_data(rd_data), .energy_efficient_enable(energy_efficient_enable),
	.deep_buffering_suspend(deep_buffering_suspend),
	.resume_done(resume_done), .evt(evt), .remote_wakeup(remote_wakeup),
	.frame_store_valid(frame_store_valid),
	.frame_store_keep(frame_store_keep), .irq(irq)
);
`default_nettype wire

/* verilog/wcs1_pkg.sv */
`default_nettype none
package wcs1_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] WCS1_OFF_WCS = 12'h140;
	localparam logic [11:0] WCS1_OFF_CTRL = 12'h148;
	localparam logic [11:0] WCS1_OFF_ISTS = 12'h14C;
	localparam logic [11:0] WCS1_OFF_IMASK = 12'h150;
	// ----------------------------------------------------------------
	// wake control and status bit positions
	// ----------------------------------------------------------------
	localparam int WCS1_B_RFE_EN = 14;
	localparam int WCS1_B_TX_FLAG = 13;
	localparam int WCS1_B_TX_EN = 12;
	localparam int WCS1_B_RX_FLAG = 11;
	localparam int WCS1_B_RX_EN = 10;
	localparam int WCS1_B_RFE_FLAG = 9;
	localparam int WCS1_B_STORE = 8;
	localparam int WCS1_B_OWN_FLAG = 7;
	localparam int WCS1_B_WUF_FLAG = 6;
	// ----------------------------------------------------------------
	// control register and interrupt bit positions
	// ----------------------------------------------------------------
	localparam int WCS1_B_RES_CLR_EN = 0;
	localparam int WCS1_B_RES_CLR_STS = 1;
	localparam int WCS1_I_TX = 0;
	localparam int WCS1_I_RX = 1;
	localparam int WCS1_I_RFE = 2;
	localparam int WCS1_I_OWN = 3;
	localparam int WCS1_I_WUF = 4;
	localparam int WCS1_NUM_INT = 5;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		WCS1_SUSP_RUN = 2'b00,
		WCS1_SUSP_ASLEEP = 2'b01,
		WCS1_SUSP_WOKEN = 2'b10
	} wcs1_susp_t;
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} wcs1_bus_t;
	typedef struct packed {
		logic tx_lpi_exit;
		logic tx_exit_by_delay;
		logic rx_lpi_wake;
		logic frame_done;
		logic frame_ok;
		logic filter_pass;
		logic own_addr;
		logic wake_frame;
	} wcs1_evt_t;
	typedef struct packed {
		logic filter_engine_wake_enable;
		logic tx_lowpower_wake_flag;
		logic tx_lowpower_wake_enable;
		logic rx_lowpower_wake_flag;
		logic rx_lowpower_wake_enable;
		logic filter_engine_wake_frame_flag;
		logic store_wake_frame;
		logic own_address_frame_flag;
		logic wake_frame_flag;
		logic resume_clears_enables;
		logic resume_clears_status;
		logic [WCS1_NUM_INT-1:0] int_sts;
		logic [WCS1_NUM_INT-1:0] int_mask;
		logic [31:0] rd_data;
		wcs1_susp_t susp;
		logic wake;
		logic store_v;
		logic store_k;
	} wcs1_state_t;
	localparam wcs1_state_t WCS1_ST_RST = '0;
endpackage
`default_nettype wire

/* verilog/wcs1_top.sv */
// How it works
// [R1] software keeps all wake enables clear in normal operation
// [R2] filter engine enable raises wakeup on clean filter-passing frame
// [R3] resume completion clears enables 14, 12, 10 when control set
// [R4] tx flag sets when tx leaves idle on request delay expiry
// [R5] tx flag never sets while tx wake enable is clear
// [R6] both low-power flags held zero while energy efficient disabled
// [R7] resume completion clears flags 13, 11, 9, 7, 6 when control set
// [R8] tx wake enable raises wakeup on any tx low-power idle exit
// [R9] rx flag sets on rx wake signaling, only when enabled
// [R10] rx wake enable raises wakeup on partner wake signaling
// [R11] filter frame flag sets on clean frame passing filter engine
// [R12] store bit set keeps waking frame and later good frames
// [R13] store bit clear drops waking frame, keeps later good frames
// [R14] non-frame wake keeps all later qualifying frames
// [R15] store bit matters only in deep buffering suspend
// [R16] own address flag sets on valid frame matching own address
// [R17] wake frame flag sets on valid remote wakeup frame
// [R18] write one clears flags, zero keeps; all reset zero
`default_nettype none
module wcs1_top
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// register port
	input wire wcs1_pkg::wcs1_bus_t bus_req,
	output logic [31:0] rd_data,
	// mac state
	input wire logic energy_efficient_enable,
	input wire logic deep_buffering_suspend,
	input wire logic resume_done,
	// wake events
	input wire wcs1_pkg::wcs1_evt_t evt,
	// wake and frame results
	output logic remote_wakeup,
	output logic frame_store_valid,
	output logic frame_store_keep,
	// interrupt
	output logic irq
);
	import wcs1_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	wcs1_state_t st_reg;
	wcs1_state_t st_next;
	logic wr_wcs;
	logic wr_ctrl;
	logic wr_mask;
	logic rd_ists;
	logic qual;
	logic valid_frame;
	logic tx_set;
	logic rx_set;
	logic rfe_set;
	logic own_set;
	logic wuf_set;
	logic frame_wake;
	logic lpi_wake;
	logic clr_en;
	logic clr_sts;
	logic [WCS1_NUM_INT-1:0] int_set;
	logic [31:0] wcs_word;
	logic tx_flag_next;
	logic rx_flag_next;
	logic rfe_flag_next;
	logic own_flag_next;
	logic wuf_flag_next;

	// ----------------------------------------------------------------
	// decode and events
	// ----------------------------------------------------------------
	always_comb
	begin
		wr_wcs = bus_req.wr && (bus_req.addr == WCS1_OFF_WCS);
		wr_ctrl = bus_req.wr && (bus_req.addr == WCS1_OFF_CTRL);
		wr_mask = bus_req.wr && (bus_req.addr == WCS1_OFF_IMASK);
		rd_ists = bus_req.rd && (bus_req.addr == WCS1_OFF_ISTS);
		valid_frame = evt.frame_done && evt.frame_ok;
		qual = valid_frame && evt.filter_pass;
		tx_set = evt.tx_lpi_exit && evt.tx_exit_by_delay
			&& st_reg.tx_lowpower_wake_enable
			&& energy_efficient_enable; // [R4] [R5]
		rx_set = evt.rx_lpi_wake && st_reg.rx_lowpower_wake_enable
			&& energy_efficient_enable; // [R9]
		rfe_set = qual; // [R11]
		own_set = valid_frame && evt.own_addr; // [R16]
		wuf_set = valid_frame && evt.wake_frame; // [R17]
		frame_wake = qual && st_reg.filter_engine_wake_enable; // [R2]
		lpi_wake = (evt.tx_lpi_exit && st_reg.tx_lowpower_wake_enable)
			|| (evt.rx_lpi_wake
			&& st_reg.rx_lowpower_wake_enable); // [R8] [R10]
		clr_en = resume_done && st_reg.resume_clears_enables;
		clr_sts = resume_done && st_reg.resume_clears_status;
		int_set = '0;
		int_set[WCS1_I_TX] = tx_set;
		int_set[WCS1_I_RX] = rx_set;
		int_set[WCS1_I_RFE] = rfe_set;
		int_set[WCS1_I_OWN] = own_set;
		int_set[WCS1_I_WUF] = wuf_set;
	end

	// ----------------------------------------------------------------
	// sticky flags
	// ----------------------------------------------------------------
	wcs1_sticky #(.WIDTH(1)) u_tx_flag
	(
		.cur(st_reg.tx_lowpower_wake_flag),
		.w1c(wr_wcs && bus_req.wdata[WCS1_B_TX_FLAG]), // [R18]
		.clr(clr_sts), // [R7]
		.set(tx_set), // [R4]
		.hold_low(!energy_efficient_enable), // [R6]
		.nxt(tx_flag_next)
	);
	wcs1_sticky #(.WIDTH(1)) u_rx_flag
	(
		.cur(st_reg.rx_lowpower_wake_flag),
		.w1c(wr_wcs && bus_req.wdata[WCS1_B_RX_FLAG]), // [R18]
		.clr(clr_sts), // [R7]
		.set(rx_set), // [R9]
		.hold_low(!energy_efficient_enable), // [R6]
		.nxt(rx_flag_next)
	);
	wcs1_sticky #(.WIDTH(1)) u_rfe_flag
	(
		.cur(st_reg.filter_engine_wake_frame_flag),
		.w1c(wr_wcs && bus_req.wdata[WCS1_B_RFE_FLAG]), // [R18]
		.clr(clr_sts), // [R7]
		.set(rfe_set), // [R11]
		.hold_low(1'b0),
		.nxt(rfe_flag_next)
	);
	wcs1_sticky #(.WIDTH(1)) u_own_flag
	(
		.cur(st_reg.own_address_frame_flag),
		.w1c(wr_wcs && bus_req.wdata[WCS1_B_OWN_FLAG]), // [R18]
		.clr(clr_sts), // [R7]
		.set(own_set), // [R16]
		.hold_low(1'b0),
		.nxt(own_flag_next)
	);
	wcs1_sticky #(.WIDTH(1)) u_wuf_flag
	(
		.cur(st_reg.wake_frame_flag),
		.w1c(wr_wcs && bus_req.wdata[WCS1_B_WUF_FLAG]), // [R18]
		.clr(clr_sts), // [R7]
		.set(wuf_set), // [R17]
		.hold_low(1'b0),
		.nxt(wuf_flag_next)
	);

	// ----------------------------------------------------------------
	// register image
	// ----------------------------------------------------------------
	always_comb
	begin
		wcs_word = 32'h0000_0000;
		wcs_word[WCS1_B_RFE_EN] = st_reg.filter_engine_wake_enable;
		wcs_word[WCS1_B_TX_FLAG] = st_reg.tx_lowpower_wake_flag;
		wcs_word[WCS1_B_TX_EN] = st_reg.tx_lowpower_wake_enable;
		wcs_word[WCS1_B_RX_FLAG] = st_reg.rx_lowpower_wake_flag;
		wcs_word[WCS1_B_RX_EN] = st_reg.rx_lowpower_wake_enable;
		wcs_word[WCS1_B_RFE_FLAG] = st_reg.filter_engine_wake_frame_flag;
		wcs_word[WCS1_B_STORE] = st_reg.store_wake_frame;
		wcs_word[WCS1_B_OWN_FLAG] = st_reg.own_address_frame_flag;
		wcs_word[WCS1_B_WUF_FLAG] = st_reg.wake_frame_flag;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		st_next = st_reg;
		st_next.rd_data = 32'h0000_0000;
		st_next.wake = frame_wake || lpi_wake; // [R2] [R8] [R10]
		st_next.store_v = evt.frame_done;
		st_next.store_k = 1'b0;

		// enables and store option
		if (wr_wcs)
		begin
			st_next.filter_engine_wake_enable =
				bus_req.wdata[WCS1_B_RFE_EN];
			st_next.tx_lowpower_wake_enable = bus_req.wdata[WCS1_B_TX_EN];
			st_next.rx_lowpower_wake_enable = bus_req.wdata[WCS1_B_RX_EN];
			st_next.store_wake_frame = bus_req.wdata[WCS1_B_STORE];
		end
		if (clr_en)
		begin
			st_next.filter_engine_wake_enable = 1'b0; // [R3]
			st_next.tx_lowpower_wake_enable = 1'b0; // [R3]
			st_next.rx_lowpower_wake_enable = 1'b0; // [R3]
		end

		// sticky flags from their cells
		st_next.tx_lowpower_wake_flag = tx_flag_next;
		st_next.rx_lowpower_wake_flag = rx_flag_next;
		st_next.filter_engine_wake_frame_flag = rfe_flag_next;
		st_next.own_address_frame_flag = own_flag_next;
		st_next.wake_frame_flag = wuf_flag_next;

		// resume control
		if (wr_ctrl)
		begin
			st_next.resume_clears_enables =
				bus_req.wdata[WCS1_B_RES_CLR_EN];
			st_next.resume_clears_status =
				bus_req.wdata[WCS1_B_RES_CLR_STS];
		end

		// interrupt status and mask
		if (wr_mask)
		begin
			st_next.int_mask = bus_req.wdata[WCS1_NUM_INT-1:0];
		end
		if (rd_ists)
		begin
			st_next.int_sts = int_set;
		end
		else
		begin
			st_next.int_sts = st_reg.int_sts | int_set;
		end

		// read data, one cycle after the strobe
		if (bus_req.rd)
		begin
			case (bus_req.addr)
				WCS1_OFF_WCS:
				begin
					st_next.rd_data = wcs_word;
				end
				WCS1_OFF_CTRL:
				begin
					st_next.rd_data[WCS1_B_RES_CLR_EN] =
						st_reg.resume_clears_enables;
					st_next.rd_data[WCS1_B_RES_CLR_STS] =
						st_reg.resume_clears_status;
				end
				WCS1_OFF_ISTS:
				begin
					st_next.rd_data[WCS1_NUM_INT-1:0] = st_reg.int_sts;
				end
				WCS1_OFF_IMASK:
				begin
					st_next.rd_data[WCS1_NUM_INT-1:0] = st_reg.int_mask;
				end
				default:
				begin
					st_next.rd_data = 32'h0000_0000;
				end
			endcase
		end

		// suspend tracking and frame storing
		case (st_reg.susp)
			WCS1_SUSP_RUN:
			begin
				st_next.store_k = qual; // [R15]
				if (deep_buffering_suspend)
				begin
					st_next.susp = WCS1_SUSP_ASLEEP;
				end
			end
			WCS1_SUSP_ASLEEP:
			begin
				if (!deep_buffering_suspend)
				begin
					st_next.store_k = qual; // [R15]
					st_next.susp = WCS1_SUSP_RUN;
				end
				else if (frame_wake)
				begin
					st_next.store_k = st_reg.store_wake_frame; // [R12] [R13]
					st_next.susp = WCS1_SUSP_WOKEN;
				end
				else if (lpi_wake)
				begin
					st_next.susp = WCS1_SUSP_WOKEN; // [R14]
				end
			end
			WCS1_SUSP_WOKEN:
			begin
				st_next.store_k = qual; // [R12] [R13] [R14]
				if (!deep_buffering_suspend)
				begin
					st_next.susp = WCS1_SUSP_RUN;
				end
			end
			default:
			begin
				st_next.susp = WCS1_SUSP_RUN;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_reg <= WCS1_ST_RST; // [R18]
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign rd_data = st_reg.rd_data;
	assign remote_wakeup = st_reg.wake;
	assign frame_store_valid = st_reg.store_v;
	assign frame_store_keep = st_reg.store_k;
	assign irq = |(st_reg.int_sts & st_reg.int_mask);
endmodule // wcs1_top

// ----------------------------------------------------------------
// sticky flag cell
// ----------------------------------------------------------------
module wcs1_sticky
#(
	parameter int WIDTH = 1
)
(
	// present value
	input wire logic [WIDTH-1:0] cur,
	// clears
	input wire logic [WIDTH-1:0] w1c,
	input wire logic clr,
	// events and forced low
	input wire logic [WIDTH-1:0] set,
	input wire logic [WIDTH-1:0] hold_low,
	// next value
	output logic [WIDTH-1:0] nxt
);
	import wcs1_pkg::*;

	// set beats both clears, forced low beats all
	always_comb
	begin
		nxt = cur & ~w1c; // [R18]
		if (clr)
		begin
			nxt = '0; // [R7]
		end
		nxt = nxt | set;
		nxt = nxt & ~hold_low; // [R6]
	end
endmodule // wcs1_sticky
`default_nettype wire
